/* File: dv/ring_line_model.sv */
// far side of the ring pin block: oversample clock, line clocks, receive data
// assumes clk is the 40 MHz bench clock; everything moves just after its rising edge
`timescale 1ns/1ps
module ring_line_model (
  input  wire logic clk,
  input  wire logic rx_clock_pin_out,
  input  wire logic rx_clock_pin_oe,
  input  wire logic tx_clock_pin_out,
  input  wire logic tx_clock_pin_oe,
  output logic      oversample_clk_in,
  output logic      rx_data_in,
  output logic      rx_clock_pin_in,
  output logic      tx_clock_pin_in
);
  logic [3:0] ovs_cnt = 4'h0;
  logic [3:0] tx_cnt  = 4'h0;
  logic       ovs     = 1'b0;
  logic       rx_clock_pin     = 1'b0;
  logic       tx_clock_pin     = 1'b0;
  // period 16 clk keeps the sampler well clear of aliasing; line clocks 16 and 24 clk
  always @(posedge clk) begin
    ovs_cnt <= ovs_cnt + 4'h1;
    tx_cnt <= (tx_cnt == 4'hb) ? 4'h0 : tx_cnt + 4'h1;
    if (ovs_cnt[2:0] == 3'h7) ovs <= ~ovs;
    if (ovs_cnt[2:0] == 3'h3) rx_clock_pin <= ~rx_clock_pin;
    if (tx_cnt == 4'hb) tx_clock_pin <= ~tx_clock_pin;
  end
  assign oversample_clk_in = ovs;
  // steady light: no transitions, so the missing-signal detector has to trip
  assign rx_data_in = 1'b1;
  // once the block drives a clock pin our driver is off the wire
  assign rx_clock_pin_in = rx_clock_pin_oe ? rx_clock_pin_out : rx_clock_pin;
  assign tx_clock_pin_in = tx_clock_pin_oe ? tx_clock_pin_out : tx_clock_pin;
endmodule

/* File: dv/ring_pin_monitor.sv */
// pin relations of the ring serial block, checked at its own ports
// assumes bind into serial_ring_pin_control and a 3-flop pin synchroniser
`timescale 1ns/1ps
module ring_pin_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        byte_order_select,
  input wire logic        addr_bit0,
  input wire logic [15:0] bus_word_in,
  input wire logic [7:0]  byte_lane_out,
  input wire logic        regen_enable_in,
  input wire logic        rx_clock_pin_oe,
  input wire logic        tx_clock_pin_oe,
  input wire logic        tx_own_in,
  input wire logic        transmitting_n,
  input wire logic        tx_bit_take,
  input wire logic        tx_data_in,
  input wire logic        tx_nrz_out,
  input wire logic        oversample_clk_in,
  input wire logic        oversample_half_out,
  input wire logic        oversample_quarter_out,
  input wire logic        test_light_sel,
  input wire logic        tx_line_out_first,
  input wire logic [4:0]  tx_line_out_extra
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // six steady samples cover the synchroniser plus the output register
  bord_low_a: assert property (
    !byte_order_select [*6] |=> byte_lane_out == ($past(addr_bit0) ? $past(bus_word_in[15:8]) : $past(bus_word_in[7:0])))
    else $error("byte lane wrong with order pin low");
  bord_high_a: assert property (
    byte_order_select [*6] |=> byte_lane_out == ($past(addr_bit0) ? $past(bus_word_in[7:0]) : $past(bus_word_in[15:8])))
    else $error("byte lane wrong with order pin high");
  regen_off_a: assert property (!regen_enable_in [*6] |-> !rx_clock_pin_oe && !tx_clock_pin_oe)
    else $error("clock pin driven with regeneration off");
  regen_on_a: assert property (regen_enable_in [*6] |-> rx_clock_pin_oe && tx_clock_pin_oe)
    else $error("clock pin not driven with regeneration on");
  tx_idle_a: assert property (1'b1 |=> transmitting_n == !$past(tx_own_in))
    else $error("transmit active pin disagrees with own data");
  nrz_take_a: assert property (tx_bit_take |-> $past(tx_own_in) && tx_nrz_out == $past(tx_data_in))
    else $error("nrz bit is not the bit taken");
  half_clk_a: assert property ($rose(oversample_clk_in) |-> ##[1:8] $changed(oversample_half_out))
    else $error("half clock missed an oversample edge");
  quarter_clk_a: assert property ($changed(oversample_quarter_out) |-> $fell(oversample_half_out))
    else $error("quarter clock out of step with half clock");
  light_test_a: assert property (!test_light_sel [*6] |-> tx_line_out_first && (&tx_line_out_extra))
    else $error("light test not forcing all line outputs");
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the ring serial pin block
// assumes the line model on the far side and the monitor bound in at the foot
`timescale 1ns/1ps
module tb_top;
  import serial_ring_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, rd_pend = 1'b0;
  logic        addr_bit0 = 1'b0, byte_order_select = 1'b0, regen_enable_in = 1'b0, baud_select_in = 1'b0;
  logic        tx_own_in = 1'b0, tx_data_in = 1'b0, test_light_sel = 1'b1, test_zero_sel = 1'b1;
  logic        cycle_sync_in = 1'b0;
  logic [7:0]  reg_addr = 8'h00, byte_lane_out;
  logic [15:0] reg_wdata = 16'h0000, bus_word_in = 16'h0000, reg_rdata;
  logic [31:0] seed = 32'h0c40;
  logic [4:0]  tx_line_out_extra, tx_line_out_extra_oe;
  logic        irq_out_first, irq_out_second, oversample_clk_in, rx_data_in, rx_clock_pin_in, rx_clock_pin_out;
  logic        rx_clock_pin_oe, tx_clock_pin_in, tx_clock_pin_out, tx_clock_pin_oe, tx_bit_take, receiving_n;
  logic        transmitting_n, tx_line_out_first, tx_line_out_first_oe, tx_nrz_out, line_fault_n;
  logic        control_strobe_out, divided_strobe_out, oversample_half_out, oversample_quarter_out;
  logic [15:0] exp_q[$];
  int          err_total = 0, n_checks = 0, c_take, c_con, c_div;

  serial_ring_pin_control u_dut (.*);
  ring_line_model u_line (.clk(clk), .rx_clock_pin_out(rx_clock_pin_out), .rx_clock_pin_oe(rx_clock_pin_oe),
    .tx_clock_pin_out(tx_clock_pin_out), .tx_clock_pin_oe(tx_clock_pin_oe), .oversample_clk_in(oversample_clk_in),
    .rx_data_in(rx_data_in), .rx_clock_pin_in(rx_clock_pin_in), .tx_clock_pin_in(tx_clock_pin_in));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // fresh random data-path inputs every cycle, so the monitor sees real traffic
  always @(posedge clk) begin
    seed <= xs(seed);
    tx_data_in <= seed[0];
    addr_bit0 <= seed[1];
    bus_word_in <= seed[23:8];
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // read data stands only in the cycle after the strobe, so the oldest note is due then
  always @(posedge clk) begin
    if (rd_pend) chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_pend <= reg_read;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  // ends just past an edge so its updates have landed
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // tick pulses and active strobe cycles, sampled mid-cycle
  task automatic count(input int n, input logic p);
    c_take = 0;
    c_con = 0;
    c_div = 0;
    repeat (n) begin
      @(negedge clk);
      c_take += int'(tx_bit_take === 1'b1);
      c_con += int'(control_strobe_out === ~p);
      c_div += int'(divided_strobe_out === ~p);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard, about six times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [15:0] v;
    int          k;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    rd(REG_CTRL, CTRL_RESET);
    rd(8'h3c, 16'h0000);
    v = seed[15:0];
    wr(REG_TXCFG, v);
    rd(REG_TXCFG, v);
    pause(40);
    chk("first_oe", 16'(tx_line_out_first_oe), 16'(!v[0]));
    chk("rx_idle", 16'(receiving_n), 16'h0001);
    for (k = 0; k < 5; k++) begin
      chk("extra_out", 16'(tx_line_out_extra[k]), 16'(v[6+k] ? v[11+k] : 1'b1));
      chk("extra_oe", 16'(tx_line_out_extra_oe[k]), 16'(v[6+k] || !v[1+k]));
    end
    wr(REG_TXCFG, 16'h0000);
    // zero stream by pin, then light over it, then zero and light in turn by software override
    test_zero_sel <= 1'b0;
    pause(60);
    chk("nrz_zero", 16'(tx_nrz_out), 16'h0000);
    chk("line_zero", 16'(tx_line_out_first), 16'h0000);
    test_light_sel <= 1'b0;
    pause(10);
    chk("line_light", 16'(tx_line_out_first), 16'h0001);
    test_light_sel <= 1'b1;
    test_zero_sel <= 1'b1;
    wr(REG_CTRL, 16'h0018);
    pause(60);
    chk("ovr_zero", 16'(tx_line_out_first), 16'h0000);
    wr(REG_CTRL, 16'h0028);
    pause(10);
    chk("ovr_light", 16'(tx_line_out_first), 16'h0001);
    // own data clocked by transmit pin, then by receive pin in repeater mode
    tx_own_in <= 1'b1;
    byte_order_select <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wr(REG_CTRL, CTRL_RESET | 16'(k));
      count(480, 1'b0);
      chk("rep_ticks", 16'(c_take >= (k ? 29 : 19) && c_take <= (k ? 31 : 21)), 16'h0001);
    end
    // regenerated baud: pin choice, then software override both ways; missing-signal on
    regen_enable_in <= 1'b1;
    for (k = 0; k < 4; k++) begin
      baud_select_in <= k[0];
      wr(REG_CTRL, 16'h00b0 | (k[1] ? {13'h0000, !k[0], 2'b10} : 16'h0000));
      count(2048, 1'b0);
      chk("baud_ticks", 16'(c_take >= (k[0] ^ k[1] ? 3 : 7) && c_take <= (k[0] ^ k[1] ? 5 : 9)), 16'h0001);
    end
    for (k = 0; k < 12000 && line_fault_n !== 1'b0; k++) @(posedge clk);
    pause(1);
    chk("line_fault", 16'(line_fault_n), 16'h0000);
    regen_enable_in <= 1'b0;
    tx_own_in <= 1'b0;
    byte_order_select <= 1'b0;
    // cycle start raises irq0, cleared by software; irq1 idles at its low polarity
    wr(REG_CTRL, CTRL_RESET);
    wr(REG_STATUS, 16'h001f);
    wr(REG_IRQCFG, 16'h0808);
    pause(3);
    chk("irq1_idle", 16'(irq_out_second), 16'h0001);
    chk("irq0_idle", 16'(irq_out_first), 16'h0000);
    cycle_sync_in <= 1'b1;
    pause(10);
    chk("irq0_set", 16'(irq_out_first), 16'h0001);
    wr(REG_STATUS, 16'h0008);
    pause(3);
    chk("irq0_clr", 16'(irq_out_first), 16'h0000);
    // strobes after a falling, then a rising cycle edge, with both output polarities
    wr(REG_CON_TIME, 16'h0005);
    wr(REG_CON_WIDTH, 16'h0003);
    wr(REG_DIV_START, 16'h0003);
    wr(REG_DIV_IVAL, 16'h000a);
    for (k = 0; k < 2; k++) begin
      wr(REG_DIV_CFG, 16'h0002 | {7'h00, k[0], 8'h00});
      wr(REG_CTRL, CTRL_RESET | {6'h00, k[0], 2'b00, cycle_sync_in, 6'h00});
      pause(5);
      cycle_sync_in <= ~cycle_sync_in;
      count(300, k[0]);
      chk("con_width", 16'(c_con), 16'h0003);
      chk("div_width", 16'(c_div), 16'(2 * DIV_PULSE_CYC_I));
    end
    report_and_stop();
  end
endmodule

bind serial_ring_pin_control ring_pin_monitor u_mon (.*);

/* File: verilog/serial_ring_pin_control.sv */
// pin-level control of the ring serial side: clock regeneration, transmit pins, strobes
// assumes pins arrive asynchronous to clk and the oversampling clock is well below clk/3
`timescale 1ns/1ps

module serial_ring_pin_control
  import serial_ring_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [REG_DW-1:0] reg_rdata,
  input  wire logic              byte_order_select,
  input  wire logic              addr_bit0,
  input  wire logic [15:0]       bus_word_in,
  output logic      [7:0]        byte_lane_out,
  output logic                   irq_out_first,
  output logic                   irq_out_second,
  input  wire logic              regen_enable_in,
  input  wire logic              baud_select_in,
  input  wire logic              oversample_clk_in,
  input  wire logic              rx_data_in,
  input  wire logic              rx_clock_pin_in,
  output logic                   rx_clock_pin_out,
  output logic                   rx_clock_pin_oe,
  input  wire logic              tx_clock_pin_in,
  output logic                   tx_clock_pin_out,
  output logic                   tx_clock_pin_oe,
  input  wire logic              tx_own_in,
  input  wire logic              tx_data_in,
  output logic                   tx_bit_take,
  output logic                   receiving_n,
  output logic                   transmitting_n,
  output logic                   tx_line_out_first,
  output logic                   tx_line_out_first_oe,
  output logic      [4:0]        tx_line_out_extra,
  output logic      [4:0]        tx_line_out_extra_oe,
  output logic                   tx_nrz_out,
  input  wire logic              test_light_sel,
  input  wire logic              test_zero_sel,
  output logic                   line_fault_n,
  input  wire logic              cycle_sync_in,
  output logic                   control_strobe_out,
  output logic                   divided_strobe_out,
  output logic                   oversample_half_out,
  output logic                   oversample_quarter_out
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
    logic [SYNC_W-1:0] filt_prev;
    logic [15:0]       ctrl;
    logic [15:0]       txcfg;
    logic [15:0]       irqcfg;
    logic [15:0]       con_time;
    logic [15:0]       con_width;
    logic [15:0]       div_start;
    logic [15:0]       div_ival;
    logic [15:0]       div_cfg;
    logic [EV_W-1:0]   pending;
    logic [15:0]       rdata;
    logic [7:0]        byte_out;
    logic [4:0]        os_cnt;
    logic [4:0]        tx_cnt;
    logic [1:0]        ovs_div;
    logic              rx_edge_seen;
    logic              rx_clk_level;
    logic              tx_clk_level;
    logic [7:0]        rx_shift;
    logic [7:0]        bit_cnt;
    logic              receiving;
    logic [7:0]        silence;
    logic [3:0]        distort;
    logic              fault;
    logic              tx_bit;
    logic              line_bit;
    logic              own;
    logic              tx_take;
    logic [15:0]       cyc_timer;
    logic              con_armed;
    logic [15:0]       con_left;
    logic [7:0]        div_pulses;
    logic [15:0]       div_gap;
    logic [5:0]        div_width;
    logic              con_out;
    logic              div_out;
    logic              irq0;
    logic              irq1;
  } state_t;

  state_t s;
  state_t next_s;

  // counters that stop at zero rather than wrapping
  function automatic logic [15:0] dec_to_zero(input logic [15:0] v);
    dec_to_zero = (v == 16'h0000) ? 16'h0000 : 16'(v - 16'h0001);
  endfunction

  // saturating count keeps a stale cycle from wrapping into a false strobe time
  function automatic logic [15:0] inc_sat(input logic [15:0] v);
    inc_sat = (v == 16'hffff) ? v : 16'(v + 16'h0001);
  endfunction

  logic [SYNC_W-1:0] pins;

  // all asynchronous pins pass the same three-stage filter
  assign pins = {byte_order_select, test_zero_sel, test_light_sel, baud_select_in, regen_enable_in,
                 cycle_sync_in, tx_clock_pin_in, rx_clock_pin_in, rx_data_in, oversample_clk_in};

  always_comb begin
    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] fall;
    logic              regen;
    logic              repeater;
    logic              baud_hi;
    logic [4:0]        last;
    logic [4:0]        half;
    logic [4:0]        quarter;
    logic              ovs_edge;
    logic              rx_trans;
    logic              rx_data;
    logic              sample_tick;
    logic              tx_regen_tick;
    logic              tx_tick;
    logic              light_on;
    logic              zero_on;
    logic              flag_hit;
    logic              missing;
    logic              cyc_edge;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   clr;
    logic [15:0]       rd;
    rise          = s.filt & ~s.filt_prev;
    fall          = ~s.filt & s.filt_prev;
    regen         = s.filt[SI_REGEN];
    repeater      = s.ctrl[CTRL_REPEATER];
    baud_hi       = s.ctrl[CTRL_BAUD_OVR] ? s.ctrl[CTRL_BAUD_VAL] : s.filt[SI_BAUD];
    last          = baud_hi ? BAUD_LAST_HIGH : BAUD_LAST_LOW;
    half          = {1'b0, last[4:1]};
    quarter       = {2'b00, last[4:2]};
    ovs_edge      = rise[SI_OVS];
    rx_data       = s.filt[SI_RXD];
    rx_trans      = rise[SI_RXD] | fall[SI_RXD];
    sample_tick   = 1'b0;
    tx_regen_tick = 1'b0;
    flag_hit      = 1'b0;
    ev            = '0;
    clr           = '0;
    rd            = 16'h0000;
    next_s        = s;

    // second and third stage must agree before a pin change counts
    next_s.s1        = pins;
    next_s.s2        = s.s1;
    next_s.s3        = s.s2;
    next_s.filt_prev = s.filt;
    for (int i = 0; i < SYNC_W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.filt[i] = s.s3[i];
      end
    end

    // byte lane selection, registered
    next_s.byte_out = (addr_bit0 ^ s.filt[SI_BORD]) ? bus_word_in[15:8] : bus_word_in[7:0];

    // oversampling divider, receive realignment and transmit baud divider
    if (rx_trans) begin
      next_s.rx_edge_seen = 1'b1;
    end
    if (ovs_edge) begin
      next_s.ovs_div = 2'(s.ovs_div + 2'b01);
      if (s.rx_edge_seen | rx_trans) begin
        next_s.os_cnt       = 5'h00;
        next_s.rx_edge_seen = 1'b0;
        // an edge far from the bit boundary counts as distortion
        if ((s.os_cnt > quarter) && (s.os_cnt < 5'(last - quarter))) begin
          next_s.distort = (s.distort == DISTORT_LIMIT) ? s.distort : 4'(s.distort + 4'h1);
        end else begin
          next_s.distort = 4'h0;
        end
      end else if (s.os_cnt >= last) begin
        next_s.os_cnt = 5'h00;
      end else begin
        next_s.os_cnt = 5'(s.os_cnt + 5'h01);
      end
      sample_tick = regen && (s.os_cnt == half);
      if (s.tx_cnt >= last) begin
        next_s.tx_cnt = 5'h00;
        tx_regen_tick = 1'b1;
      end else begin
        next_s.tx_cnt = 5'(s.tx_cnt + 5'h01);
      end
    end
    next_s.rx_clk_level = regen && (s.os_cnt > half);
    next_s.tx_clk_level = regen && (s.tx_cnt > half);
    if (!regen) begin
      sample_tick = rise[SI_RXC];
    end

    // transmitter clock source
    if (regen) begin
      tx_tick = tx_regen_tick;
    end else if (repeater) begin
      tx_tick = rise[SI_RXC];
    end else begin
      tx_tick = rise[SI_TXC];
    end

    // receive shift, telegram framing by flag bytes
    if (sample_tick) begin
      next_s.rx_shift = {s.rx_shift[6:0], rx_data};
      flag_hit        = ({s.rx_shift[6:0], rx_data} == FLAG_PATTERN);
      next_s.bit_cnt  = (s.bit_cnt == 8'hff) ? s.bit_cnt : 8'(s.bit_cnt + 8'h01);
      next_s.silence  = (s.silence == SILENCE_BITS) ? s.silence : 8'(s.silence + 8'h01);
    end
    if (rx_trans) begin
      next_s.silence = 8'h00;
    end
    missing = (s.silence == SILENCE_BITS);
    if (flag_hit && !s.receiving) begin
      next_s.receiving = 1'b1;
      next_s.bit_cnt   = 8'h00;
      ev[EV_RX_START]  = 1'b1;
    end else if (s.receiving && ((flag_hit && (s.bit_cnt >= MIN_TELEGRAM)) || missing)) begin
      next_s.receiving = 1'b0;
      ev[EV_RX_END]    = 1'b1;
    end

    // line fault, each cause enabled separately
    next_s.fault = (s.ctrl[CTRL_FLT_MISS] && missing) ||
                   (s.ctrl[CTRL_FLT_DIST] && (s.distort == DISTORT_LIMIT));
    ev[EV_FAULT] = next_s.fault & ~s.fault;

    // transmit path and test generator
    light_on     = ~(s.ctrl[CTRL_TEST_OVR] ? s.ctrl[CTRL_LIGHT_VAL] : s.filt[SI_LIGHT]);
    zero_on      = ~(s.ctrl[CTRL_TEST_OVR] ? s.ctrl[CTRL_ZERO_VAL] : s.filt[SI_ZERO]);
    next_s.own     = tx_own_in;
    ev[EV_TX_END]  = s.own & ~tx_own_in;
    next_s.tx_take = tx_tick & tx_own_in;
    if (tx_tick) begin
      if (zero_on) begin
        next_s.tx_bit = 1'b0;
      end else if (tx_own_in) begin
        next_s.tx_bit = tx_data_in;
      end else if (repeater) begin
        next_s.tx_bit = rx_data;
      end else begin
        next_s.tx_bit = 1'b1;
      end
    end
    next_s.line_bit = light_on | next_s.tx_bit;

    // communication cycle timing
    cyc_edge         = s.ctrl[CTRL_CYC_FALL] ? fall[SI_CYC] : rise[SI_CYC];
    next_s.cyc_timer = inc_sat(s.cyc_timer);
    if (s.con_armed && (s.cyc_timer == s.con_time)) begin
      next_s.con_armed = 1'b0;
      next_s.con_left  = s.con_width;
    end else begin
      next_s.con_left = dec_to_zero(s.con_left);
    end
    if (s.div_width != 6'h00) begin
      next_s.div_width = 6'(s.div_width - 6'h01);
    end else if (s.div_pulses != 8'h00) begin
      if (s.div_gap == 16'h0000) begin
        next_s.div_width  = DIV_PULSE_CYC;
        next_s.div_gap    = dec_to_zero(s.div_ival);
        next_s.div_pulses = 8'(s.div_pulses - 8'h01);
      end else begin
        next_s.div_gap = dec_to_zero(s.div_gap);
      end
    end
    if (cyc_edge) begin
      next_s.cyc_timer  = 16'h0000;
      next_s.con_armed  = 1'b1;
      next_s.div_pulses = s.div_cfg[DIV_CNT_LSB +: DIV_CNT_W];
      next_s.div_gap    = s.div_start;
      ev[EV_CYCLE]      = 1'b1;
    end
    next_s.con_out = (s.con_left != 16'h0000) ^ s.ctrl[CTRL_CON_LOW];
    next_s.div_out = (s.div_width != 6'h00) ^ s.div_cfg[DIV_LOW];

    // register writes; status bits are write-one-to-clear
    if (reg_write) begin
      unique case (reg_addr)
        REG_CTRL:      next_s.ctrl      = reg_wdata;
        REG_TXCFG:     next_s.txcfg     = reg_wdata;
        REG_IRQCFG:    next_s.irqcfg    = reg_wdata;
        REG_STATUS:    clr              = reg_wdata[EV_W-1:0];
        REG_CON_TIME:  next_s.con_time  = reg_wdata;
        REG_CON_WIDTH: next_s.con_width = reg_wdata;
        REG_DIV_START: next_s.div_start = reg_wdata;
        REG_DIV_IVAL:  next_s.div_ival  = reg_wdata;
        REG_DIV_CFG:   next_s.div_cfg   = reg_wdata;
        default:       ;
      endcase
    end
    // a new event outweighs a clear in the same cycle
    next_s.pending = (s.pending & ~clr) | ev;
    next_s.irq0 = (|(s.pending & s.irqcfg[IRQ0_SRC_LSB +: EV_W])) ^ s.irqcfg[IRQ0_LOW];
    next_s.irq1 = (|(s.pending & s.irqcfg[IRQ1_SRC_LSB +: EV_W])) ^ s.irqcfg[IRQ1_LOW];

    // read data valid only in the cycle after the strobe
    if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL:      rd = s.ctrl;
        REG_TXCFG:     rd = s.txcfg;
        REG_IRQCFG:    rd = s.irqcfg;
        REG_STATUS:    rd = {s.rx_shift, regen, s.fault, s.receiving, s.pending};
        REG_CON_TIME:  rd = s.con_time;
        REG_CON_WIDTH: rd = s.con_width;
        REG_DIV_START: rd = s.div_start;
        REG_DIV_IVAL:  rd = s.div_ival;
        REG_DIV_CFG:   rd = s.div_cfg;
        default:       rd = 16'h0000;
      endcase
    end
    next_s.rdata = rd;
  end

  // the whole state; async reset loads constants only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s      <= '0;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // pin drivers from registered state
  assign reg_rdata              = s.rdata;
  assign byte_lane_out          = s.byte_out;
  assign irq_out_first          = s.irq0;
  assign irq_out_second         = s.irq1;
  assign rx_clock_pin_out       = s.rx_clk_level;
  assign rx_clock_pin_oe        = s.filt[SI_REGEN];
  assign tx_clock_pin_out       = s.tx_clk_level;
  assign tx_clock_pin_oe        = s.filt[SI_REGEN];
  assign tx_bit_take            = s.tx_take;
  assign receiving_n            = ~s.receiving;
  assign transmitting_n         = ~s.own;
  assign tx_line_out_first      = s.line_bit;
  assign tx_line_out_first_oe   = ~s.txcfg[TX_FIRST_HIZ];
  assign tx_nrz_out             = s.tx_bit;
  assign line_fault_n           = ~s.fault;
  assign control_strobe_out     = s.con_out;
  assign divided_strobe_out     = s.div_out;
  assign oversample_half_out    = s.ovs_div[0];
  assign oversample_quarter_out = s.ovs_div[1];

  // port mode bits beat the high-impedance choice; a port bit is always driven
  always_comb begin
    for (int i = 0; i < TX_EXTRA_N; i++) begin
      tx_line_out_extra[i]    = s.txcfg[TX_PORT_LSB + i] ? s.txcfg[TX_PVAL_LSB + i] : s.line_bit;
      tx_line_out_extra_oe[i] = s.txcfg[TX_PORT_LSB + i] | ~s.txcfg[TX_HIZ_LSB + i];
    end
  end

endmodule

/* File: verilog/serial_ring_pkg.sv */
// constants for the ring serial pin-control block: register offsets, fields, timing
// assumes a single 40 MHz clock domain and a plain register port with 16-bit data
package serial_ring_pkg;

  // clock and timing
  localparam int          CLK_MHZ         = 40;
  localparam int          DIV_PULSE_NS    = 1000;                         // divided strobe pulse width
  localparam int          DIV_PULSE_CYC_I = (DIV_PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [5:0]  DIV_PULSE_CYC   = 6'(DIV_PULSE_CYC_I);

  // register port
  localparam int          REG_AW          = 8;
  localparam int          REG_DW          = 16;
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_TXCFG       = 8'h04;
  localparam logic [7:0]  REG_IRQCFG      = 8'h08;
  localparam logic [7:0]  REG_STATUS      = 8'h0c;
  localparam logic [7:0]  REG_CON_TIME    = 8'h10;
  localparam logic [7:0]  REG_CON_WIDTH   = 8'h14;
  localparam logic [7:0]  REG_DIV_START   = 8'h18;
  localparam logic [7:0]  REG_DIV_IVAL    = 8'h1c;
  localparam logic [7:0]  REG_DIV_CFG     = 8'h20;

  // control register fields
  localparam int          CTRL_REPEATER   = 0;
  localparam int          CTRL_BAUD_OVR   = 1;
  localparam int          CTRL_BAUD_VAL   = 2;
  localparam int          CTRL_TEST_OVR   = 3;
  localparam int          CTRL_LIGHT_VAL  = 4;
  localparam int          CTRL_ZERO_VAL   = 5;
  localparam int          CTRL_CYC_FALL   = 6;
  localparam int          CTRL_FLT_MISS   = 7;
  localparam int          CTRL_FLT_DIST   = 8;
  localparam int          CTRL_CON_LOW    = 9;
  localparam logic [15:0] CTRL_RESET      = 16'h0030;                     // test levels idle high

  // transmit configuration fields
  localparam int          TX_FIRST_HIZ    = 0;
  localparam int          TX_HIZ_LSB      = 1;
  localparam int          TX_PORT_LSB     = 6;
  localparam int          TX_PVAL_LSB     = 11;
  localparam int          TX_EXTRA_N      = 5;

  // interrupt configuration fields
  localparam int          IRQ0_SRC_LSB    = 0;
  localparam int          IRQ1_SRC_LSB    = 5;
  localparam int          IRQ0_LOW        = 10;
  localparam int          IRQ1_LOW        = 11;

  // divided strobe configuration fields
  localparam int          DIV_CNT_LSB     = 0;
  localparam int          DIV_CNT_W       = 8;
  localparam int          DIV_LOW         = 8;

  // event bits
  localparam int          EV_RX_START     = 0;
  localparam int          EV_RX_END       = 1;
  localparam int          EV_FAULT        = 2;
  localparam int          EV_CYCLE        = 3;
  localparam int          EV_TX_END       = 4;
  localparam int          EV_W            = 5;

  // status read layout
  localparam int          ST_RECEIVING    = 5;
  localparam int          ST_FAULT        = 6;
  localparam int          ST_REGEN        = 7;
  localparam int          ST_SHIFT_LSB    = 8;

  // synchronised pin vector positions
  localparam int          SI_OVS          = 0;
  localparam int          SI_RXD          = 1;
  localparam int          SI_RXC          = 2;
  localparam int          SI_TXC          = 3;
  localparam int          SI_CYC          = 4;
  localparam int          SI_REGEN        = 5;
  localparam int          SI_BAUD         = 6;
  localparam int          SI_LIGHT        = 7;
  localparam int          SI_ZERO         = 8;
  localparam int          SI_BORD         = 9;
  localparam int          SYNC_W          = 10;

  // receiver constants
  localparam int          BAUD_DIV_LOW    = 16;
  localparam int          BAUD_DIV_HIGH   = 32;
  localparam logic [4:0]  BAUD_LAST_LOW   = 5'(BAUD_DIV_LOW - 1);
  localparam logic [4:0]  BAUD_LAST_HIGH  = 5'(BAUD_DIV_HIGH - 1);
  localparam logic [7:0]  FLAG_PATTERN    = 8'h7e;
  localparam logic [7:0]  MIN_TELEGRAM    = 8'h10;
  localparam logic [7:0]  SILENCE_BITS    = 8'h20;
  localparam logic [3:0]  DISTORT_LIMIT   = 4'h4;

endpackage
